// [pgc_pkg.sv]
// Shared constants, types and helpers for the clock synthesis control block
package pgc_pkg;

	// Clock and timing
	localparam int CLK_MHZ      = 250;
	localparam int LOSS_TIME_NS = 400;
	localparam int LOSS_CYC     = (LOSS_TIME_NS * CLK_MHZ) / 1000;
	localparam int LOSS_W       = 9;
	localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(LOSS_CYC);

	// Counter geometry
	localparam int CNT_W   = 11;
	localparam int MEAS_W  = 16;
	localparam int N_REGN  = 2;
	localparam int N_GLB   = 4;
	localparam int N_EXT   = 4;
	localparam int N_GATED = N_REGN + N_GLB;
	localparam int N_PORT  = N_GATED + N_EXT;
	localparam logic [CNT_W-1:0] CNT_ONE      = 11'h001;
	localparam logic [CNT_W-1:0] PRE_MAX      = 11'h200;
	localparam logic [CNT_W-1:0] FB_MAX       = 11'h200;
	localparam logic [CNT_W-1:0] POST_MAX_50  = 11'h400;
	localparam logic [CNT_W-1:0] POST_MAX_ODD = 11'h200;

	// Lock detection
	localparam logic [2:0]        LOCK_GOOD = 3'h4;
	localparam logic [MEAS_W-1:0] LOCK_TOL  = 16'h0001;

	// Register byte addresses
	localparam logic [7:0] ADR_PRE    = 8'h00;
	localparam logic [7:0] ADR_FB     = 8'h04;
	localparam logic [7:0] ADR_GATE   = 8'h08;
	localparam logic [7:0] ADR_DUTY   = 8'h0c;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	localparam logic [7:0] ADR_POST   = 8'h40;
	localparam logic [7:0] ADR_POST_END = 8'h68;

	// Reset values
	localparam logic [CNT_W-1:0]   DIV_RST  = 11'h001;
	localparam logic [N_GATED-1:0] GATE_RST = 6'h3f;
	localparam logic [N_PORT-1:0]  DUTY_RST = 10'h3ff;

	// Input synchroniser bit positions
	localparam int SY_PRI = 0;
	localparam int SY_SEC = 1;
	localparam int SY_EN  = 2;
	localparam int SY_ARS = 3;
	localparam int SY_DET = 4;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pgc_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pgc_wb_rsp_t;

	typedef struct packed {
		logic locked;
		logic clk_loss;
		logic ref_sel;
	} pgc_stat_t;

	// Zero reads as one; values above the ceiling saturate
	function automatic logic [CNT_W-1:0] pgc_clamp(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] hi);
		if (v == '0)
			return CNT_ONE;
		else if (v > hi)
			return hi;
		else
			return v;
	endfunction : pgc_clamp

endpackage : pgc_pkg

// [pgc_postdiv.sv]
// Post-scale divider with falling-edge sampled output clock gate
`timescale 1ns/1ps
module pgc_postdiv (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Control
	input  wire logic                     clr_i,
	input  wire logic [pgc_pkg::CNT_W-1:0] div_i,
	input  wire logic                     duty50_i,
	input  wire logic                     gate_i,
	// Output clock
	output      logic                     clk_o
);
	import pgc_pkg::*;

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] eff;
	logic [CNT_W-1:0] hi;
	logic             div_reg;
	logic             div_next;
	logic             en_reg;

	always_comb begin
		eff = duty50_i ? pgc_clamp(div_i, POST_MAX_50) : pgc_clamp(div_i, POST_MAX_ODD);
		hi  = duty50_i ? CNT_W'((eff + CNT_ONE) >> 1) : CNT_ONE;
		if (clr_i || cnt_reg >= eff - CNT_ONE)
			cnt_next = '0;
		else
			cnt_next = cnt_reg + CNT_ONE;
		div_next = !clr_i && (cnt_next < hi);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			div_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			div_reg <= div_next;
		end
	end

	// Gate only changes while the divided clock is low
	always_ff @(posedge clk_i) begin
		if (rst_i)
			en_reg <= 1'b0;
		else if (clr_i || (div_reg && !div_next))
			en_reg <= gate_i;
	end

	assign clk_o = div_reg & en_reg;

	gate_glitch_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(en_reg) |-> !div_reg)
		else $error("Output gate changed while divided clock high");

	count_in_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$stable(div_i) && $stable(duty50_i) |-> cnt_reg < eff)
		else $error("Post-scale count beyond programmed divide");

	odd_duty_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!duty50_i && $stable(div_i) && eff > CNT_ONE && $rose(div_reg) |=> !div_reg)
		else $error("Non-half duty output high longer than one cycle");

endmodule : pgc_postdiv

// [pgc_top.sv]
// Clock synthesis control: scale counters, reference switchover, enables, output gating
// What this block does
// - One pre-scale, one feedback counter, range 1-512
// - Oscillator equals input times feedback over pre-scale
// - Each output port has its own post-scale divider
// - Two regional, four global, four external; 1-1024
// - Non-half duty cycle limits post-scale to 512
// - Switch to secondary reference when primary absent
// - Enable low: outputs zero, lock dropped
// - Enable high again: relock and resynchronise outputs
// - Reset high: counters cleared, outputs zero, unlocked
// - Reset released: resynchronise to reference while relocking
// - Detector disabled: hold setting, outputs keep running
// - Regional and global ports have own gate
// - Gate sampled on falling edge of divided clock
// - Output gating never touches the feedback loop
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module pgc_top (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Register bus
	input  wire pgc_pkg::pgc_wb_req_t      wb_req_i,
	output      pgc_pkg::pgc_wb_rsp_t      wb_rsp_o,
	// Reference clocks and control pins
	input  wire logic                      ref_pri_i,
	input  wire logic                      ref_sec_i,
	input  wire logic                      pll_enable_i,
	input  wire logic                      pll_areset_i,
	input  wire logic                      phase_freq_detector_en_i,
	// Output clocks and status
	output      logic [pgc_pkg::N_PORT-1:0] pll_clk_o,
	output      pgc_pkg::pgc_stat_t        status_o
);
	import pgc_pkg::*;

	// Registers
	logic [CNT_W-1:0]   pre_reg;
	logic [CNT_W-1:0]   fb_reg;
	logic [N_GATED-1:0] gate_reg;
	logic [N_PORT-1:0]  duty_reg;
	logic [CNT_W-1:0]   post_reg [N_PORT];
	logic               ack_reg;
	logic [31:0]        rdat_reg;

	// Synchronisers and reference sense
	logic [4:0]         sy1_reg;
	logic [4:0]         sy2_reg;
	logic [1:0]         ref_dly_reg;
	logic [1:0]         ref_edge;
	logic [LOSS_W-1:0]  loss_cnt_reg [2];
	logic [1:0]         absent;
	logic               ref_sel_reg;
	logic               act_edge;
	logic               act_absent;
	logic               clk_loss_reg;

	// Loop state
	logic               run_reg;
	logic               synced_reg;
	logic               locked_reg;
	logic [CNT_W-1:0]   n_cnt_reg;
	logic [MEAS_W-1:0]  meas_reg;
	logic [MEAS_W-1:0]  ctrl_word_reg;
	logic [2:0]         good_reg;
	logic [CNT_W-1:0]   n_eff;
	logic [CNT_W-1:0]   m_eff;
	logic [MEAS_W-1:0]  period;
	logic               tick;
	logic               match;
	logic               div_clr;

	// Bus decode
	logic               req;
	logic               wr_now;
	logic               post_hit;
	logic [3:0]         post_idx;
	logic [7:0]         post_off;
	logic [31:0]        rd_mux;

	// Input synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sy1_reg     <= '0;
			sy2_reg     <= '0;
			ref_dly_reg <= '0;
		end else begin
			sy1_reg     <= {phase_freq_detector_en_i, pll_areset_i, pll_enable_i, ref_sec_i, ref_pri_i};
			sy2_reg     <= sy1_reg;
			ref_dly_reg <= sy2_reg[SY_SEC:SY_PRI];
		end
	end

	assign ref_edge = sy2_reg[SY_SEC:SY_PRI] & ~ref_dly_reg;

	// Per-reference absence detectors
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sense
			always_ff @(posedge clk_i) begin
				if (rst_i || ref_edge[gi])
					loss_cnt_reg[gi] <= '0;
				else if (loss_cnt_reg[gi] < LOSS_LIMIT)
					loss_cnt_reg[gi] <= loss_cnt_reg[gi] + LOSS_W'(1);
			end
			assign absent[gi] = (loss_cnt_reg[gi] >= LOSS_LIMIT);
		end
	endgenerate

	// Reference switchover, cleared by loop reset
	always_ff @(posedge clk_i) begin
		if (rst_i || sy2_reg[SY_ARS])
			ref_sel_reg <= 1'b0;
		else if (!ref_sel_reg && absent[0])
			ref_sel_reg <= 1'b1;
	end

	assign act_edge   = ref_sel_reg ? ref_edge[1] : ref_edge[0];
	assign act_absent = ref_sel_reg ? absent[1] : absent[0];

	always_ff @(posedge clk_i) begin
		if (rst_i)
			clk_loss_reg <= 1'b0;
		else
			clk_loss_reg <= act_absent;
	end

	// Loop runs only while enabled and out of reset
	always_ff @(posedge clk_i) begin
		if (rst_i)
			run_reg <= 1'b0;
		else
			run_reg <= sy2_reg[SY_EN] && !sy2_reg[SY_ARS];
	end

	// Pre-scale and feedback measurement
	always_comb begin
		n_eff  = pgc_clamp(pre_reg, PRE_MAX);
		m_eff  = pgc_clamp(fb_reg, FB_MAX);
		tick   = act_edge && (n_cnt_reg >= n_eff - CNT_ONE);
		period = meas_reg + MEAS_W'(1);
		// Oscillator cycles per n reference edges must be within LOCK_TOL of m
		match  = (period + LOCK_TOL >= MEAS_W'(m_eff)) && (period <= MEAS_W'(m_eff) + LOCK_TOL);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !run_reg) begin
			n_cnt_reg <= '0;
			meas_reg  <= '0;
		end else begin
			if (tick)
				n_cnt_reg <= '0;
			else if (act_edge)
				n_cnt_reg <= n_cnt_reg + CNT_ONE;
			if (tick)
				meas_reg <= '0;
			else if (meas_reg != '1)
				meas_reg <= meas_reg + MEAS_W'(1);
		end
	end

	// Outputs restart aligned to the first pre-scale tick after release
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_reg)
			synced_reg <= 1'b0;
		else if (tick)
			synced_reg <= 1'b1;
	end

	// Lock detection, frozen while the detector is disabled
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_reg) begin
			locked_reg <= 1'b0;
			good_reg   <= '0;
		end else if (sy2_reg[SY_DET]) begin
			if (act_absent) begin
				locked_reg <= 1'b0;
				good_reg   <= '0;
			end else if (tick && synced_reg) begin
				if (!match) begin
					locked_reg <= 1'b0;
					good_reg   <= '0;
				end else if (good_reg >= LOCK_GOOD - 3'h1) begin
					locked_reg <= 1'b1;
				end else begin
					good_reg <= good_reg + 3'h1;
				end
			end
		end
	end

	// Last control setting, held while the detector is disabled
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_reg)
			ctrl_word_reg <= '0;
		else if (sy2_reg[SY_DET] && tick && synced_reg)
			ctrl_word_reg <= period;
	end

	// Dividers are cleared only by enable, reset and resync, never by gates
	assign div_clr = !run_reg || !synced_reg;

	generate
		for (gi = 0; gi < N_PORT; gi++) begin : g_port
			pgc_postdiv u_div (
				.clk_i    (clk_i),
				.rst_i    (rst_i),
				.clr_i    (div_clr),
				.div_i    (post_reg[gi]),
				.duty50_i (duty_reg[gi]),
				.gate_i   ((gi < N_GATED) ? gate_reg[gi % N_GATED] : 1'b1),
				.clk_o    (pll_clk_o[gi])
			);
		end
	endgenerate

	assign status_o = '{locked: locked_reg, clk_loss: clk_loss_reg, ref_sel: ref_sel_reg};

	// Wishbone slave
	assign req      = wb_req_i.cyc && wb_req_i.stb;
	assign wr_now   = req && wb_req_i.we && ack_reg;
	assign post_hit = (wb_req_i.adr >= ADR_POST) && (wb_req_i.adr < ADR_POST_END);
	assign post_off = wb_req_i.adr - ADR_POST;
	assign post_idx = post_off[5:2];

	function automatic logic [CNT_W-1:0] lane_merge(input logic [CNT_W-1:0] old, input pgc_wb_req_t r);
		logic [CNT_W-1:0] v;
		v = old;
		if (r.sel[0])
			v[7:0] = r.dat[7:0];
		if (r.sel[1])
			v[CNT_W-1:8] = r.dat[CNT_W-1:8];
		return v;
	endfunction : lane_merge

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= '0;
		end else begin
			ack_reg  <= req && !ack_reg;
			rdat_reg <= rd_mux;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_reg  <= DIV_RST;
			fb_reg   <= DIV_RST;
			gate_reg <= GATE_RST;
			duty_reg <= DUTY_RST;
		end else if (wr_now) begin
			if (wb_req_i.adr == ADR_PRE)
				pre_reg <= lane_merge(pre_reg, wb_req_i);
			if (wb_req_i.adr == ADR_FB)
				fb_reg <= lane_merge(fb_reg, wb_req_i);
			if (wb_req_i.adr == ADR_GATE && wb_req_i.sel[0])
				gate_reg <= wb_req_i.dat[N_GATED-1:0];
			if (wb_req_i.adr == ADR_DUTY && wb_req_i.sel[0])
				duty_reg[7:0] <= wb_req_i.dat[7:0];
			if (wb_req_i.adr == ADR_DUTY && wb_req_i.sel[1])
				duty_reg[N_PORT-1:8] <= wb_req_i.dat[N_PORT-1:8];
		end
	end

	generate
		for (gi = 0; gi < N_PORT; gi++) begin : g_post
			always_ff @(posedge clk_i) begin
				if (rst_i)
					post_reg[gi] <= DIV_RST;
				else if (wr_now && post_hit && post_idx == 4'(gi))
					post_reg[gi] <= lane_merge(post_reg[gi], wb_req_i);
			end
		end
	endgenerate

	always_comb begin
		rd_mux = '0;
		if (post_hit)
			rd_mux[CNT_W-1:0] = post_reg[post_idx];
		else begin
			unique case (wb_req_i.adr)
				ADR_PRE:    rd_mux[CNT_W-1:0] = pre_reg;
				ADR_FB:     rd_mux[CNT_W-1:0] = fb_reg;
				ADR_GATE:   rd_mux[N_GATED-1:0] = gate_reg;
				ADR_DUTY:   rd_mux[N_PORT-1:0] = duty_reg;
				ADR_STATUS: rd_mux = {ctrl_word_reg, 12'h000, synced_reg, ref_sel_reg, clk_loss_reg, locked_reg};
				default:    rd_mux = '0;
			endcase
		end
	end

	assign wb_rsp_o = '{ack: ack_reg, dat: rdat_reg};

	// Checks
	disabled_outputs_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!run_reg |=> pll_clk_o == '0 && !locked_reg)
		else $error("Outputs or lock active while loop disabled");

	reset_drops_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sy2_reg[SY_ARS] |-> ##2 !locked_reg && n_cnt_reg == '0 && pll_clk_o == '0)
		else $error("Loop reset did not clear counters and lock");

	resync_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		run_reg && !synced_reg |=> pll_clk_o == '0)
		else $error("Output clock before resynchronisation tick");

	lock_needs_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(locked_reg) |-> $past(tick) && $past(match) && $past(sy2_reg[SY_DET]))
		else $error("Lock asserted without frequency match");

	switchover_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ref_sel_reg && absent[0] && !sy2_reg[SY_ARS] |=> ref_sel_reg)
		else $error("No switchover on absent primary reference");

	loss_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
		act_absent ##1 $stable(ref_sel_reg) |-> clk_loss_reg)
		else $error("Loss status missing while reference absent");

	detector_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		run_reg && !sy2_reg[SY_DET] ##1 run_reg |-> $stable(locked_reg) && $stable(ctrl_word_reg))
		else $error("Loop state moved while detector disabled");

	pre_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		n_eff >= CNT_ONE && n_eff <= PRE_MAX && m_eff >= CNT_ONE && m_eff <= FB_MAX)
		else $error("Scale counter outside one to 512");

	ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_reg |=> !ack_reg)
		else $error("Bus acknowledge held longer than one cycle");

	loss_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!act_absent |=> !clk_loss_reg)
		else $error("Loss status stuck after reference edges resumed");

	sync_on_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		run_reg && !synced_reg && tick |=> synced_reg)
		else $error("Outputs not resynchronised at first pre-scale tick");

	enable_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!sy2_reg[SY_EN] |-> ##2 !locked_reg && pll_clk_o == '0)
		else $error("Outputs or lock active while enable pin low");

endmodule : pgc_top

// [pgc_partner.sv]
// Fabric-side model: reference clocks and loop control pins
`timescale 1ns/1ps
module pgc_partner (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Commands from the bench
	input  wire logic pri_run_i,
	input  wire logic sec_run_i,
	input  wire logic en_cmd_i,
	input  wire logic rst_cmd_i,
	input  wire logic det_cmd_i,
	input  wire logic det_by_loss_i,
	input  wire logic clk_loss_i,
	// Pins toward the block
	output logic      ref_pri_o,
	output logic      ref_sec_o,
	output logic      pll_enable_o,
	output logic      pll_areset_o,
	output logic      det_en_o
);
	logic [2:0] ph_reg;
	logic [1:0] hold_reg;

	// References run at one eighth of the system clock
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ph_reg <= 3'h0;
		else
			ph_reg <= ph_reg + 3'h1;
	end

	// Loop reset request stretched to four cycles
	always_ff @(posedge clk_i) begin
		if (rst_i)
			hold_reg <= 2'h0;
		else if (rst_cmd_i)
			hold_reg <= 2'h3;
		else if (hold_reg != 2'h0)
			hold_reg <= hold_reg - 2'h1;
	end

	// Stopped references rest low
	assign ref_pri_o    = pri_run_i & ph_reg[2];
	assign ref_sec_o    = sec_run_i & ph_reg[2];
	assign pll_enable_o = en_cmd_i;
	assign pll_areset_o = rst_cmd_i | (hold_reg != 2'h0);
	assign det_en_o     = det_by_loss_i ? ~clk_loss_i : det_cmd_i;
endmodule : pgc_partner

// [tb_pgc_top.sv]
// Self-checking bench for the clock synthesis control block
`timescale 1ns/1ps
module tb_pgc_top;
	import pgc_pkg::*;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	pgc_wb_req_t       req = '0;
	pgc_wb_rsp_t       rsp;
	logic              pri = 1'b0;
	logic              sec = 1'b0;
	logic              det_ctl = 1'b0;
	logic              by_loss = 1'b0;
	logic              en = 1'b0;
	logic              ars = 1'b0;
	logic              ref_pri, ref_sec, pen, pars, det_pin;
	logic [N_PORT-1:0] pll_clk;
	pgc_stat_t         st;
	int                failures = 0;
	int                comparisons = 0;
	int                cycles = 0;
	logic [31:0]       q;
	int                hi, lo;

	always #2 clk = ~clk;

	pgc_partner partner_u (.clk_i(clk), .rst_i(rst), .pri_run_i(pri), .sec_run_i(sec), .en_cmd_i(en),
		.rst_cmd_i(ars), .det_cmd_i(det_ctl), .det_by_loss_i(by_loss), .clk_loss_i(st.clk_loss),
		.ref_pri_o(ref_pri), .ref_sec_o(ref_sec), .pll_enable_o(pen), .pll_areset_o(pars), .det_en_o(det_pin));

	pgc_top dut_u (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_rsp_o(rsp), .ref_pri_i(ref_pri),
		.ref_sec_i(ref_sec), .pll_enable_i(pen), .pll_areset_i(pars), .phase_freq_detector_en_i(det_pin),
		.pll_clk_o(pll_clk), .status_o(st));

	task automatic report_and_stop();
		$display("Counts: comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
		@(posedge clk);
		while (rsp.ack !== 1'b1)
			@(posedge clk);
		q = rsp.dat;
		req <= '0;
	endtask : wb

	task automatic wait_st(input int b, input logic v, input int lim);
		int n;
		n = 0;
		while (st[b] !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, st[b]}, {31'h0, v});
	endtask : wait_st

	// Length of the next full high and low phase of a port
	task automatic meas(input int p, input int eh, input int el);
		int n;
		n = 0;
		hi = 0;
		lo = 0;
		while (pll_clk[p] !== 1'b0 && n < 3000) begin @(posedge clk); n++; end
		while (pll_clk[p] !== 1'b1 && n < 3000) begin @(posedge clk); n++; end
		while (pll_clk[p] === 1'b1 && n < 3000) begin @(posedge clk); n++; hi++; end
		while (pll_clk[p] === 1'b0 && n < 3000) begin @(posedge clk); n++; lo++; end
		chk(hi, eh);
		chk(lo, el);
	endtask : meas

	task automatic t_regs();
		wb(0, ADR_PRE, 0); chk(q, 32'h1);
		wb(0, ADR_FB, 0); chk(q, 32'h1);
		wb(0, ADR_GATE, 0); chk(q, 32'h3f);
		wb(0, ADR_DUTY, 0); chk(q, 32'h3ff);
		wb(0, ADR_POST, 0); chk(q, 32'h1);
		wb(0, ADR_POST + 8'h24, 0); chk(q, 32'h1);
		wb(1, 8'h20, 32'h5a);
		wb(0, 8'h20, 0); chk(q, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_lock();
		pri <= 1'b1;
		en <= 1'b1;
		det_ctl <= 1'b1;
		wb(1, ADR_PRE, 32'h0);
		wb(1, ADR_FB, 32'h8);
		wait_st(2, 1'b1, 400);
		wb(0, ADR_STATUS, 0); chk(q[31:16], 32'h8);
		wb(1, ADR_PRE, 32'h2);
		wb(1, ADR_FB, 32'h9);
		wait_st(2, 1'b0, 400);
		wb(1, ADR_FB, 32'h10);
		wait_st(2, 1'b1, 600);
		$display("test lock done");
	endtask : t_lock

	task automatic t_post();
		wb(1, ADR_POST, 32'h5);
		wb(1, ADR_POST + 8'h4, 32'h7ff);
		wb(1, ADR_DUTY, 32'h3fb);
		wb(1, ADR_POST + 8'h8, 32'h7ff);
		meas(0, 3, 2);
		meas(1, 512, 512);
		meas(1, 512, 512);
		meas(2, 1, 511);
		meas(2, 1, 511);
		$display("test post done");
	endtask : t_post

	task automatic t_gate();
		wb(1, ADR_GATE, 32'h3e);
		repeat (10) @(posedge clk);
		repeat (20) begin
			@(posedge clk);
			chk(pll_clk[0], 1'b0);
			chk(pll_clk[9:6], 4'hf);
		end
		chk(st.locked, 1'b1);
		wb(1, ADR_GATE, 32'h3f);
		meas(0, 3, 2);
		$display("test gate done");
	endtask : t_gate

	task automatic t_hold();
		det_ctl <= 1'b0;
		repeat (10) @(posedge clk);
		pri <= 1'b0;
		wait_st(0, 1'b1, 300);
		wait_st(1, 1'b1, 300);
		chk(st.locked, 1'b1);
		meas(0, 3, 2);
		by_loss <= 1'b1;
		sec <= 1'b1;
		wait_st(1, 1'b0, 300);
		chk(st.ref_sel, 1'b1);
		repeat (10) @(posedge clk);
		by_loss <= 1'b0;
		det_ctl <= 1'b1;
		$display("test hold done");
	endtask : t_hold

	task automatic t_areset();
		pri <= 1'b1;
		wb(1, ADR_GATE, 32'h0);
		repeat (12) @(posedge clk);
		ars <= 1'b1;
		@(posedge clk);
		ars <= 1'b0;
		repeat (6) @(posedge clk);
		chk(pll_clk, '0);
		chk(st.locked, 1'b0);
		chk(st.ref_sel, 1'b0);
		wait_st(2, 1'b1, 600);
		wb(1, ADR_GATE, 32'h3f);
		meas(0, 3, 2);
		$display("test areset done");
	endtask : t_areset

	task automatic t_enable();
		en <= 1'b0;
		repeat (8) @(posedge clk);
		chk(pll_clk, '0);
		chk(st.locked, 1'b0);
		repeat (30) @(posedge clk);
		chk(pll_clk, '0);
		en <= 1'b1;
		wait_st(2, 1'b1, 600);
		meas(0, 3, 2);
		$display("test enable done");
	endtask : t_enable

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_lock();
		t_post();
		t_gate();
		t_hold();
		t_areset();
		t_enable();
		report_and_stop();
	end
endmodule : tb_pgc_top
